// ==== spp_pkg.sv ====
package spp_pkg;
    // memory geometry: sectors, 4KB subsectors per sector, volatile lock units
    localparam int SPP_NSEC = 8;
    localparam int SPP_NSUB = 16;
    localparam int SPP_NVU = 2 * SPP_NSUB + SPP_NSEC - 2;
    localparam int SPP_AW = 7;  // global subsector index width
    localparam int SPP_UW = 6;  // volatile unit index width

    // protection mode register
    localparam logic [15:0] SPP_PMODE_RST = 16'hffff;  // as delivered, reserved bits read 1
    localparam int SPP_PM_PW = 2;   // password mode selector
    localparam int SPP_PM_SEC = 1;  // sector protection lock

    // volatile and nonvolatile state after reset
    localparam logic SPP_FREEZE_RST = 1'b1;
    localparam logic SPP_NV_RST = 1'b1;        // delivered: unlocked
    localparam logic [63:0] SPP_PW_RST = 64'hffff_ffff_ffff_ffff;
    localparam logic [1:0] SPP_VL_RST = 2'h0;
    localparam int SPP_VL_WLOCK = 0;  // per-unit write lock bit
    localparam int SPP_VL_LDOWN = 1;  // per-unit lock-down bit

    // command opcodes on the serial link (first byte of a frame)
    localparam logic [7:0] SPP_OP_RD_PMODE = 8'h2d;
    localparam logic [7:0] SPP_OP_WR_PMODE = 8'h2c;
    localparam logic [7:0] SPP_OP_RD_FREEZE = 8'ha7;
    localparam logic [7:0] SPP_OP_WR_FREEZE = 8'ha6;
    localparam logic [7:0] SPP_OP_UNLOCK = 8'h29;
    localparam logic [7:0] SPP_OP_PROG_PW = 8'h28;
    localparam logic [7:0] SPP_OP_RD_PW = 8'h27;
    localparam logic [7:0] SPP_OP_WR_NV = 8'he3;
    localparam logic [7:0] SPP_OP_ER_NV = 8'he4;
    localparam logic [7:0] SPP_OP_RD_NV = 8'he2;
    localparam logic [7:0] SPP_OP_WR_VL = 8'he5;
    localparam logic [7:0] SPP_OP_RD_VL = 8'he8;
    localparam logic [7:0] SPP_OP_SOFT_RST = 8'h99;

    // exact frame lengths in bytes, opcode included, and the byte counter's saturation value
    localparam logic [3:0] SPP_LEN_OPC = 4'h1;
    localparam logic [3:0] SPP_LEN_ADDR = 4'h2;
    localparam logic [3:0] SPP_LEN_PMODE = 4'h3;
    localparam logic [3:0] SPP_LEN_VWR = 4'h3;
    localparam logic [3:0] SPP_LEN_PW = 4'h9;
    localparam logic [3:0] SPP_IDX_MAX = 4'hf;

    // received byte events from the link front end
    typedef struct packed {
        logic start;
        logic stop;
        logic valid;
        logic [7:0] data;
    } spp_rx_t;

    // program/erase permission query from the array engine
    typedef struct packed {
        logic req;
        logic [SPP_AW-1:0] addr;
    } spp_pe_t;
endpackage : spp_pkg

// ==== spp_link.sv ====
module spp_link
    import spp_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic [7:0] tx_byte_in,
    output spp_rx_t rx_out,
    output logic miso_out,
    output logic miso_oe_n_out
);
    logic sck_s1_r, sck_s2_r, sck_s3_r;  // link clock synchroniser and edge history
    logic cs_s1_r, cs_s2_r, cs_s3_r;     // select synchroniser and edge history
    logic mosi_s1_r, mosi_s2_r;          // data synchroniser
    logic [2:0] bit_r;                   // bit position within current byte
    logic [6:0] rx_sh_r;                 // incoming bits, msb first
    logic load_r;                        // next falling edge starts a new reply byte
    logic [6:0] tx_sh_r;                 // remaining reply bits
    spp_rx_t rx_r;
    logic miso_r, oe_n_r;
    logic rise, fall, fstart, fstop;

    // only the second stage feeds logic; the third is edge history
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {sck_s1_r, sck_s2_r, sck_s3_r} <= 3'h0;
            {cs_s1_r, cs_s2_r, cs_s3_r} <= 3'h7;
            {mosi_s1_r, mosi_s2_r} <= 2'h0;
        end else begin
            {sck_s1_r, sck_s2_r, sck_s3_r} <= {sck_in, sck_s1_r, sck_s2_r};
            {cs_s1_r, cs_s2_r, cs_s3_r} <= {cs_n_in, cs_s1_r, cs_s2_r};
            {mosi_s1_r, mosi_s2_r} <= {mosi_in, mosi_s1_r};
        end
    end

    // edges only count inside a frame, the link clock may idle high or low
    assign rise = sck_s2_r & ~sck_s3_r & ~cs_s2_r;
    assign fall = ~sck_s2_r & sck_s3_r & ~cs_s2_r;
    assign fstart = cs_s3_r & ~cs_s2_r;
    assign fstop = ~cs_s3_r & cs_s2_r;

    // receive side: sample on rising edge, emit one byte event per eight bits
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_r <= 3'h0;
            rx_sh_r <= 7'h00;
            rx_r <= '0;
        end else begin
            rx_r <= '0;
            rx_r.start <= fstart;
            rx_r.stop <= fstop;
            if (fstart) begin
                bit_r <= 3'h0;
            end else if (rise) begin
                bit_r <= bit_r + 3'h1;
                rx_sh_r <= {rx_sh_r[5:0], mosi_s2_r};
                if (bit_r == 3'h7) begin
                    rx_r.valid <= 1'b1;
                    rx_r.data <= {rx_sh_r, mosi_s2_r};
                end
            end
        end
    end

    // reply side: shift on falling edge; tx_byte_in must settle within half a link period
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            load_r <= 1'b0;
            tx_sh_r <= 7'h00;
            miso_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= cs_s2_r;
            if (fstart) begin
                load_r <= 1'b0;
                tx_sh_r <= 7'h00;
                miso_r <= 1'b0;
            end else begin
                if (rise && bit_r == 3'h7) begin
                    load_r <= 1'b1;
                end
                if (fall) begin
                    load_r <= 1'b0;
                    if (load_r) begin
                        miso_r <= tx_byte_in[7];
                        tx_sh_r <= tx_byte_in[6:0];
                    end else begin
                        miso_r <= tx_sh_r[6];
                        tx_sh_r <= {tx_sh_r[5:0], 1'b0};
                    end
                end
            end
        end
    end

    assign rx_out = rx_r;
    assign miso_out = miso_r;
    assign miso_oe_n_out = oe_n_r;
endmodule : spp_link

// ==== spp_protect.sv ====
// Functional notes
// R1 - sixteen-bit mode register, only bits two, one
// R2 - per-sector nonvolatile lock, zero means locked
// R3 - per-sector volatile lock, cleared on reset
// R4 - end sectors: volatile locks per 4KB subsector
// R5 - mode bit two zero: password hidden, fixed
// R6 - bit one zero forbids ever clearing bit two
// R7 - mode bits one-shot, never both zero
// R8 - host should commit one mode bit early
// R9 - host sets password first; later changes refused
// R10 - password mode: freeze set needs right password
// R11 - wrong password keeps freeze and locks
// R12 - host picks password mode before sector bit
// R13 - delivered with every sector unlocked
// R14 - freeze zero blocks nonvolatile lock changes
// R15 - host freezes only after configuring locks
// R16 - freeze read returns bit zero, rest zero
// R17 - password mode: freeze locked after reset
// R18 - correct unlock command sets freeze
// R19 - freeze write command clears freeze
// R20 - write locks one sector, erase frees all
// R21 - volatile lock-down freezes both bits until reset
// R22 - locked sector or unit refuses program, erase
module spp_protect
    import spp_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire spp_pe_t pe_in,
    output logic miso_out,
    output logic miso_oe_n_out,
    output logic pe_done_out,
    output logic pe_deny_out,
    output logic freeze_out,
    output logic pw_mode_out
);
    spp_rx_t rx;                         // byte events from the link
    logic [7:0] tx_byte;                 // reply byte offered to the link
    logic [7:0] opc_r;                   // opcode of the current frame
    logic [3:0] idx_r;                   // bytes received in the current frame
    logic [SPP_AW-1:0] addr_r;           // first argument byte
    logic [63:0] dat_r;                  // all argument bytes, last in low bits
    logic [15:0] pmode_r;                // protection mode register
    logic freeze_r;                      // global freeze bit
    logic [63:0] pw_r;                   // stored password
    logic [SPP_NSEC-1:0] nv_r;           // nonvolatile lock bits, 0 = locked
    logic [1:0] vl_r [SPP_NVU];          // volatile lock registers
    logic pe_done_r, pe_deny_r;
    logic pw_mode;                       // password protection active
    logic pw_ok;                         // argument matches stored password
    logic [SPP_UW-1:0] vsel;             // volatile unit of the current frame
    logic pw_mode_r; // registered password mode for the pin
    logic cmd_soft; // soft reset frame ends this cycle
    logic cmd_unlock; // unlock frame ends this cycle
    logic cmd_wrfz; // freeze write frame ends this cycle
    logic cmd_ernv; // lock erase frame ends this cycle

    // map a global subsector index onto a volatile lock unit
    function automatic logic [SPP_UW-1:0] spp_vunit(input logic [SPP_AW-1:0] a);
        logic [2:0] sec;
        sec = a[6:4];
        if (sec == 3'h0) begin
            spp_vunit = {2'h0, a[3:0]};                                    // [R4]
        end else if (sec == 3'(SPP_NSEC - 1)) begin
            spp_vunit = SPP_UW'(SPP_NSUB) + {2'h0, a[3:0]};                // [R4]
        end else begin
            spp_vunit = SPP_UW'(2 * SPP_NSUB - 1) + {3'h0, sec};  // whole-sector lock
        end
    endfunction : spp_vunit

    // true when the finished frame is the given command of the exact length
    function automatic logic spp_cmd(input logic [7:0] op, input logic [3:0] len);
        spp_cmd = rx.stop && (opc_r == op) && (idx_r == len);
    endfunction : spp_cmd

    spp_link u_link (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .sck_in(sck_in),
        .cs_n_in(cs_n_in),
        .mosi_in(mosi_in),
        .tx_byte_in(tx_byte),
        .rx_out(rx),
        .miso_out(miso_out),
        .miso_oe_n_out(miso_oe_n_out)
    );

    assign pw_mode = ~pmode_r[SPP_PM_PW];
    assign pw_ok = (dat_r == pw_r);
    assign vsel = spp_vunit(addr_r);

    // frame-end strobes for the checks: the function reads module state that
    // an assertion would not sample, so the checks look at these instead
    always_comb begin
        cmd_soft = spp_cmd(SPP_OP_SOFT_RST, SPP_LEN_OPC);
        cmd_unlock = spp_cmd(SPP_OP_UNLOCK, SPP_LEN_PW);
        cmd_wrfz = spp_cmd(SPP_OP_WR_FREEZE, SPP_LEN_OPC);
        cmd_ernv = spp_cmd(SPP_OP_ER_NV, SPP_LEN_OPC);
    end

    // every check runs on the system clock and rests during reset
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    // password mode flag for the pin, one cycle behind the mode register
    // so that the output comes straight from a flop
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pw_mode_r <= ~SPP_PMODE_RST[SPP_PM_PW];
        end else begin
            pw_mode_r <= pw_mode;                                          // [R5]
        end
    end

    // frame capture: opcode first, arguments shift into dat_r
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            opc_r <= 8'h00;
            idx_r <= 4'h0;
            addr_r <= '0;
            dat_r <= 64'h0;
        end else if (rx.start) begin
            idx_r <= 4'h0;
            opc_r <= 8'h00;
        end else if (rx.valid) begin
            if (idx_r == 4'h0) begin
                opc_r <= rx.data;
            end else begin
                dat_r <= {dat_r[55:0], rx.data};
            end
            if (idx_r == 4'h1) begin
                addr_r <= rx.data[SPP_AW-1:0];
            end
            // saturate so an overlong frame never wraps onto a valid length
            if (idx_r != SPP_IDX_MAX) begin
                idx_r <= idx_r + 4'h1;
            end
        end
    end

    // protection mode register: one-shot clears, mutually exclusive
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pmode_r <= SPP_PMODE_RST;
        end else if (spp_cmd(SPP_OP_WR_PMODE, SPP_LEN_PMODE)) begin
            // a request to clear both at once is refused whole
            if (!dat_r[SPP_PM_PW] && !dat_r[SPP_PM_SEC]) begin
                pmode_r <= pmode_r;                                        // [R7]
            end else if (!dat_r[SPP_PM_PW] && pmode_r[SPP_PM_SEC]) begin
                pmode_r[SPP_PM_PW] <= 1'b0;                                // [R5] [R6]
            end else if (!dat_r[SPP_PM_SEC] && pmode_r[SPP_PM_PW]) begin
                pmode_r[SPP_PM_SEC] <= 1'b0;                               // [R6] [R7]
            end
        end
    end

    // password store: programmable only while password mode is off
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pw_r <= SPP_PW_RST;
        end else if (spp_cmd(SPP_OP_PROG_PW, SPP_LEN_PW) && !pw_mode) begin
            pw_r <= dat_r;                                                 // [R5] [R9]
        end
    end

    // global freeze bit
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // hard reset also reloads the mode register, so password mode is off here
            freeze_r <= SPP_FREEZE_RST;
        end else if (spp_cmd(SPP_OP_SOFT_RST, SPP_LEN_OPC)) begin
            freeze_r <= ~pw_mode;                                          // [R17]
        end else if (spp_cmd(SPP_OP_WR_FREEZE, SPP_LEN_OPC)) begin
            freeze_r <= 1'b0;                                              // [R19]
        end else if (spp_cmd(SPP_OP_UNLOCK, SPP_LEN_PW)) begin
            // outside password mode the unlock needs no matching password
            if (pw_ok || !pw_mode) begin
                freeze_r <= 1'b1;                                          // [R10] [R18]
            end
        end
    end

    // nonvolatile lock bits, changeable only while freeze is 1
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nv_r <= {SPP_NSEC{SPP_NV_RST}};                                // [R13]
        end else if (freeze_r) begin                                       // [R11] [R14]
            if (spp_cmd(SPP_OP_WR_NV, SPP_LEN_ADDR)) begin
                nv_r[addr_r[6:4]] <= 1'b0;                                 // [R2] [R20]
            end else if (spp_cmd(SPP_OP_ER_NV, SPP_LEN_OPC)) begin
                nv_r <= {SPP_NSEC{1'b1}};                                  // [R20]
            end
        end
    end

    // volatile lock registers, one per unit
    genvar gi;
    generate
        for (gi = 0; gi < SPP_NVU; gi++) begin : g_vl
            always_ff @(posedge sys_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    vl_r[gi] <= SPP_VL_RST;                                // [R3]
                end else if (spp_cmd(SPP_OP_SOFT_RST, SPP_LEN_OPC)) begin
                    vl_r[gi] <= SPP_VL_RST;                                // [R3] [R21]
                end else if (spp_cmd(SPP_OP_WR_VL, SPP_LEN_VWR) &&
                             vsel == SPP_UW'(gi) && !vl_r[gi][SPP_VL_LDOWN]) begin
                    vl_r[gi] <= dat_r[1:0];                                // [R21]
                end
            end

            lockdown_hold_a: assert property (                             // [R21]
                vl_r[gi][SPP_VL_LDOWN] && !cmd_soft
                |=> $stable(vl_r[gi]))
                else $error("locked-down volatile register changed");
        end
    endgenerate

    // reply byte for the byte position that the host clocks next
    always_comb begin
        tx_byte = 8'h00;
        case (opc_r)
            SPP_OP_RD_PMODE: begin
                if (idx_r == 4'h1) begin
                    tx_byte = pmode_r[15:8];                               // [R1]
                end else if (idx_r == 4'h2) begin
                    tx_byte = pmode_r[7:0];
                end
            end
            SPP_OP_RD_FREEZE: begin
                tx_byte = {7'h00, freeze_r};                               // [R16]
            end
            SPP_OP_RD_NV: begin
                if (idx_r >= SPP_LEN_ADDR) begin
                    tx_byte = {7'h00, nv_r[addr_r[6:4]]};
                end
            end
            SPP_OP_RD_VL: begin
                if (idx_r >= SPP_LEN_ADDR) begin
                    tx_byte = {6'h00, vl_r[vsel]};
                end
            end
            SPP_OP_RD_PW: begin
                // in password mode the password never leaves the device
                if (!pw_mode && idx_r >= 4'h1 && idx_r < SPP_LEN_PW) begin
                    tx_byte = pw_r[8 * (9 - int'(idx_r)) - 1 -: 8];        // [R5]
                end
            end
            default: begin
                tx_byte = 8'h00;
            end
        endcase
    end

    // program/erase permission for the array engine, answered next cycle
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pe_done_r <= 1'b0;
            pe_deny_r <= 1'b0;
        end else begin
            pe_done_r <= pe_in.req;
            if (pe_in.req) begin
                pe_deny_r <= ~nv_r[pe_in.addr[6:4]] |                      // [R22]
                             vl_r[spp_vunit(pe_in.addr)][SPP_VL_WLOCK];
            end
        end
    end

    assign pe_done_out = pe_done_r;
    assign pe_deny_out = pe_deny_r;
    assign freeze_out = freeze_r;
    assign pw_mode_out = pw_mode_r;

    // building blocks of the unlock and refusal checks
    sequence unlock_bad_s;
        cmd_unlock && pw_mode && !pw_ok && !freeze_r;
    endsequence

    sequence unlock_good_s;
        cmd_unlock && pw_ok && !cmd_soft;
    endsequence

    sequence pe_locked_s;
        pe_in.req && (!nv_r[pe_in.addr[6:4]] || vl_r[spp_vunit(pe_in.addr)][SPP_VL_WLOCK]);
    endsequence

    // mode bits: exclusive, one-shot, reserved bits untouched
    mode_exclusive_a: assert property (pmode_r[SPP_PM_PW] || pmode_r[SPP_PM_SEC]) // [R7]
        else $error("both mode bits cleared");

    mode_oneshot_a: assert property (                                      // [R7]
        !$rose(pmode_r[SPP_PM_PW]) && !$rose(pmode_r[SPP_PM_SEC]))
        else $error("mode bit returned to one");

    mode_reserved_a: assert property (                                     // [R1]
        pmode_r[15:3] == SPP_PMODE_RST[15:3] && pmode_r[0] == SPP_PMODE_RST[0])
        else $error("reserved mode bits changed");

    // password mode guards the freeze bit
    bad_password_a: assert property (unlock_bad_s |=> !freeze_r [*2])      // [R11]
        else $error("wrong password released freeze");

    good_unlock_a: assert property (unlock_good_s |=> freeze_r)            // [R18]
        else $error("correct password did not set freeze");

    freeze_gate_a: assert property (                                       // [R10]
        pw_mode && !freeze_r && !(cmd_unlock && pw_ok) |=> !freeze_r)
        else $error("freeze opened without password");

    // a write frame may only close the freeze bit
    freeze_write_a: assert property (cmd_wrfz |=> !freeze_r) // [R19]
        else $error("freeze write did not clear freeze");

    // reset in password mode leaves the lock bits frozen
    reset_freeze_a: assert property (cmd_soft && pw_mode |=> !freeze_r) // [R17]
        else $error("freeze open after reset in password mode");

    // lock bits move only while the freeze bit is open
    nv_frozen_a: assert property (!freeze_r |=> $stable(nv_r))             // [R14]
        else $error("lock bits changed while frozen");

    nv_erase_a: assert property (                                          // [R20]
        freeze_r && cmd_ernv |=> nv_r == {SPP_NSEC{1'b1}})
        else $error("lock erase left a sector locked");

    // the stored password is sealed once password mode is on
    pw_sealed_a: assert property (pw_mode |=> $stable(pw_r)) // [R5] [R9]
        else $error("password changed in password mode");

    pw_hidden_a: assert property (                                         // [R5]
        opc_r == SPP_OP_RD_PW && pw_mode |-> tx_byte == 8'h00)
        else $error("password visible in password mode");

    // answers come only after a query, and refuse locked areas
    pe_refuse_a: assert property (pe_locked_s |=> pe_done_out && pe_deny_out) // [R22]
        else $error("locked area not refused");

    pe_pulse_a: assert property (!pe_in.req |=> !pe_done_out) // [R22]
        else $error("permission answer without query");
endmodule : spp_protect

// ==== spp_host.sv ====
// host controller model: mode 0 frames, clock parked low between frames
module spp_host (
    input wire logic sys_clk_in,
    input wire logic miso_in,
    input wire logic miso_oe_n_in,
    output logic sck_out,
    output logic cs_n_out,
    output logic mosi_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle link: no frame, clock standing still
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // every change lands just after a system clock edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : step

    // one frame of n bytes, msb first from the top of tx; reply shifts into rx
    task automatic xfer(input int n, input logic [71:0] tx, output logic [71:0] rx);
        rx = '0;
        cs_n_out = 1'b0;
        for (int i = 0; i < 8 * n; i++) begin
            mosi_out = tx[71 - i];
            step(8);
            // an undriven reply line reads unknown so it can never pass a compare
            rx = {rx[70:0], miso_oe_n_in ? 1'bx : miso_in};
            sck_out = 1'b1;
            step(8);
            sck_out = 1'b0;
        end
        step(8);
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;  // released line must not keep the last bit
        step(10);  // gap of ten cycles, below one sixteen-cycle link period
    endtask : xfer
endmodule : spp_host

// ==== tb_top.sv ====
module tb_top
    import spp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    spp_pe_t pe = '0;
    logic sck, cs_n, mosi, miso, miso_oe_n, pe_done, pe_deny, freeze, pw_mode;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 88499;
    // reference state of the protection logic
    logic [15:0] m_mode;
    int m_fz;
    logic [63:0] m_pw;
    int m_nv [8];
    logic [1:0] m_vl [38];
    logic [71:0] rx;

    always #5 sys_clk_in = ~sys_clk_in;

    spp_protect i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .sck_in(sck),
        .cs_n_in(cs_n), .mosi_in(mosi), .pe_in(pe), .miso_out(miso),
        .miso_oe_n_out(miso_oe_n), .pe_done_out(pe_done), .pe_deny_out(pe_deny),
        .freeze_out(freeze), .pw_mode_out(pw_mode));
    spp_host i_host (.sys_clk_in(sys_clk_in), .miso_in(miso), .miso_oe_n_in(miso_oe_n),
        .sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi));

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // a hang is cut short well above the expected run length
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            results();
        end
    end

    // end sectors lock per subsector, inner sectors as a whole
    function automatic int unit_of(input logic [6:0] a);
        if (a[6:4] == 3'h0) return int'(a[3:0]);
        if (a[6:4] == 3'h7) return 16 + int'(a[3:0]);
        return 31 + int'(a[6:4]);
    endfunction : unit_of

    // hard reset brings back the factory state
    task automatic hard_reset();
        rstn_in = 1'b0;
        i_host.step(3);
        rstn_in = 1'b1;
        m_mode = SPP_PMODE_RST;
        m_fz = 1;
        m_pw = SPP_PW_RST;
        m_nv = '{default: 1};
        m_vl = '{default: 2'h0};
        i_host.step(3);
    endtask : hard_reset

    // send a command and apply its effect to the reference state
    task automatic cmd(input int n, input logic [71:0] tx);
        logic pwm;
        logic [6:0] a;
        i_host.xfer(n, tx, rx);
        pwm = ~m_mode[SPP_PM_PW];
        a = tx[62:56];
        case (tx[71:64])
            SPP_OP_WR_FREEZE: if (n == 1) m_fz = 0;
            SPP_OP_UNLOCK: if (n == 9 && (!pwm || tx[63:0] == m_pw)) m_fz = 1;
            SPP_OP_PROG_PW: if (n == 9 && !pwm) m_pw = tx[63:0];
            SPP_OP_WR_NV: if (n == 2 && m_fz == 1) m_nv[a[6:4]] = 0;
            SPP_OP_ER_NV: if (n == 1 && m_fz == 1) m_nv = '{default: 1};
            SPP_OP_WR_VL: if (n == 3 && !m_vl[unit_of(a)][1]) m_vl[unit_of(a)] = tx[49:48];
            SPP_OP_WR_PMODE: if (n == 3 && (tx[50] || tx[49])) begin
                if (!tx[50] && m_mode[1]) m_mode[2] = 1'b0;
                if (!tx[49] && m_mode[2]) m_mode[1] = 1'b0;
            end
            SPP_OP_SOFT_RST: if (n == 1) begin
                m_vl = '{default: 2'h0};
                m_fz = pwm ? 0 : 1;
            end
            default: ;  // anything else must leave state alone
        endcase
    endtask : cmd

    // read back mode, freeze, lock bits and one volatile unit, and probe permissions
    task automatic verify(input logic [6:0] focus);
        logic [6:0] a;
        chk("freeze_out", freeze, 64'(m_fz[0]));
        chk("pw_mode_out", pw_mode, 64'(!m_mode[2]));
        i_host.xfer(3, {SPP_OP_RD_PMODE, 64'h0}, rx);
        chk("mode", rx[15:0], m_mode);
        i_host.xfer(2, {SPP_OP_RD_FREEZE, 64'h0}, rx);
        chk("freeze read", rx[7:0], {7'h0, m_fz[0]});
        for (int s = 0; s < 8; s++) begin
            i_host.xfer(3, {SPP_OP_RD_NV, 1'b0, 3'(s), 4'h0, 56'h0}, rx);
            chk("nv bit", rx[7:0], 64'(m_nv[s]));
        end
        // the unit next to the focus holds the locks that the scenarios set
        a = focus + 7'h1;
        i_host.xfer(3, {SPP_OP_RD_VL, 1'b0, a, 56'h0}, rx);
        chk("vl reg", rx[7:0], {6'h0, m_vl[unit_of(a)]});
        for (int k = 0; k < 6; k++) begin
            a = (k < 2) ? focus + 7'(k) : 7'($random(seed));
            pe.req = 1'b1;
            pe.addr = a;
            i_host.step(1);
            pe.req = 1'b0;
            chk("pe_done_out", pe_done, 64'h1);
            chk("pe_deny_out", pe_deny, 64'(m_nv[a[6:4]] == 0 || m_vl[unit_of(a)][0]));
            i_host.step(1);
        end
    endtask : verify

    initial begin
        logic [63:0] pwv;
        pwv = {$random(seed), $random(seed)};
        hard_reset();
        verify(7'h00);
        cmd(2, {SPP_OP_WR_NV, 8'h35, 56'h0});  // whole sector 3 locked
        verify(7'h35);
        cmd(3, {SPP_OP_WR_VL, 8'h05, 8'h01, 48'h0});  // one subsector of sector 0
        verify(7'h04);
        cmd(3, {SPP_OP_WR_VL, 8'h72, 8'h03, 48'h0});  // lock-down, then a refused rewrite
        cmd(3, {SPP_OP_WR_VL, 8'h72, 8'h00, 48'h0});
        verify(7'h71);
        cmd(1, {SPP_OP_ER_NV, 64'h0});  // host freezes only after configuring
        cmd(1, {SPP_OP_WR_FREEZE, 64'h0});
        cmd(2, {SPP_OP_WR_NV, 8'h60, 56'h0});
        verify(7'h60);
        cmd(1, {SPP_OP_SOFT_RST, 64'h0});
        verify(7'h71);
        cmd(9, {SPP_OP_PROG_PW, pwv});  // password set before the mode bit
        i_host.xfer(9, {SPP_OP_RD_PW, 64'h0}, rx);
        chk("password", rx[63:0], m_pw);
        cmd(2, {SPP_OP_WR_NV, 8'h10, 56'h0});
        cmd(3, {SPP_OP_WR_PMODE, 8'hff, 8'hf9, 48'h0});  // both bits at once
        cmd(3, {SPP_OP_WR_PMODE, 8'hff, 8'hfb, 48'h0});  // committed early
        cmd(9, {SPP_OP_PROG_PW, ~pwv});
        cmd(3, {SPP_OP_WR_PMODE, 8'hff, 8'hfd, 48'h0});
        i_host.xfer(9, {SPP_OP_RD_PW, 64'h0}, rx);
        chk("hidden password", rx[63:0], 64'h0);
        cmd(1, {SPP_OP_SOFT_RST, 64'h0});
        cmd(9, {SPP_OP_UNLOCK, ~pwv});
        cmd(1, {SPP_OP_ER_NV, 64'h0});
        verify(7'h10);
        cmd(9, {SPP_OP_UNLOCK, pwv});
        cmd(1, {SPP_OP_ER_NV, 64'h0});
        verify(7'h10);
        hard_reset();
        cmd(2, {SPP_OP_WR_FREEZE, 8'h00, 56'h0});  // wrong length is ignored
        cmd(3, {SPP_OP_WR_PMODE, 8'hff, 8'hfd, 48'h0});
        cmd(3, {SPP_OP_WR_PMODE, 8'hff, 8'hfb, 48'h0});
        verify(7'h00);
        results();
    end
endmodule : tb_top
